// >>> pie_bank.sv
// Peripheral interrupt enable bank with APB register access
// Assumes an APB master on pclk and level flags from the peripherals
//
// Functional notes
// - Each enable bit passes its source request at 1, blocks at 0.
// - All implemented enable bits except register 3 bits 5 and 4 are read/write and reset to zero.
// - Unimplemented positions read zero and ignore writes.
// - Register 1 bits 6..0: converter, rx1, tx1, sync port1, t1 gate, t2, t1 ovf.
// - Register 2: bit7 osc fail; bits5..0 sync2, coll2, coll1, voltage, t3 ovf, t3 gate.
// - Register 3 bits 7..0: t5 gate, display, rx2, tx2, charge, cc2, cc1, rtc.
// - Register 3 bits 5 and 4 are read-only, reset zero.
// - Display enable acts only with type-B waveform and non-static mode.
// - Register 4 bits 7..0 enable capture/compare units 10 down to 3.
// - Small-memory variant drops reg4 bits 7,6 and reg5 bits 7,6,5,3.
// - Register 5 bits 7..0: t7 gate, t12, t10, t8, t7 ovf, t6, t5 ovf, t4.
// - Register 6: bit4 write done; bits 2..0 comparators 3..1.
// - Without priority mode, global peripheral enable must also be set.
`timescale 1ns/1ps
`default_nettype none
`include "pie_defines.svh"

module pie_bank (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`PIE_AW-1:0]     paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Peripheral flags, one group per enable register
    input  wire logic [7:0]             flags1,
    input  wire logic [7:0]             flags2,
    input  wire logic [7:0]             flags3,
    input  wire logic [7:0]             flags4,
    input  wire logic [7:0]             flags5,
    input  wire logic [7:0]             flags6,
    // Core side
    output logic                        periph_irq_req,
    output logic [47:0]                 qualified_req,
    output logic                        irq
);
    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire  acc     = psel & penable;
    wire  wr_acc  = acc & pwrite & pstrb[0];
    wire  rd_acc  = acc & ~pwrite;
    wire  hit_en1 = (paddr == `PIE_OFF_EN1);
    wire  hit_en2 = (paddr == `PIE_OFF_EN2);
    wire  hit_en3 = (paddr == `PIE_OFF_EN3);
    wire  hit_en4 = (paddr == `PIE_OFF_EN4);
    wire  hit_en5 = (paddr == `PIE_OFF_EN5);
    wire  hit_en6 = (paddr == `PIE_OFF_EN6);
    wire  hit_ctl = (paddr == `PIE_OFF_CTRL);
    wire  hit_st  = (paddr == `PIE_OFF_STAT);
    wire  hit_msk = (paddr == `PIE_OFF_IMASK);
    wire  hit_rlo = (paddr == `PIE_OFF_REQ_LO);
    wire  hit_rhi = (paddr == `PIE_OFF_REQ_HI);
    wire  mapped  = hit_en1 | hit_en2 | hit_en3 | hit_en4 | hit_en5 | hit_en6
                  | hit_ctl | hit_st | hit_msk | hit_rlo | hit_rhi;
    wire  ro_hit  = hit_st | hit_rlo | hit_rhi;
    wire  bad_acc = acc & (~mapped | (pwrite & ro_hit));
    wire  we_en1  = wr_acc & hit_en1;
    wire  we_en2  = wr_acc & hit_en2;
    wire  we_en3  = wr_acc & hit_en3;
    wire  we_en4  = wr_acc & hit_en4;
    wire  we_en5  = wr_acc & hit_en5;
    wire  we_en6  = wr_acc & hit_en6;
    wire  we_ctl  = wr_acc & hit_ctl;
    wire  we_msk  = wr_acc & hit_msk;
    wire  rd_st   = rd_acc & hit_st;

    assign pready  = 1'b1;
    assign pslverr = bad_acc;

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    logic [`PIE_CTRL_W-1:0] ctrl_q;
    logic [`PIE_CTRL_W-1:0] ctrl_d;
    assign ctrl_d = we_ctl ? pwdata[`PIE_CTRL_W-1:0] : ctrl_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `PIE_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    wire small_var = ctrl_q[`PIE_CTRL_SMALL];
    wire lcd_ok    = ctrl_q[`PIE_CTRL_LCDB] & ctrl_q[`PIE_CTRL_NSTAT];
    wire glob_en   = ctrl_q[`PIE_CTRL_GLOBAL];
    wire prio_mode = ctrl_q[`PIE_CTRL_PRIO];

    // ------------------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------------------
    pie_pkg::pie_byte_t en1;
    pie_pkg::pie_byte_t en2;
    pie_pkg::pie_byte_t en3;
    pie_pkg::pie_byte_t en4;
    pie_pkg::pie_byte_t en5;
    pie_pkg::pie_byte_t en6;
    wire  [7:0] wd8 = pwdata[7:0];
    wire  [7:0] lm4 = small_var ? `PIE_SMALL_MASK4 : 8'hff;
    wire  [7:0] lm5 = small_var ? `PIE_SMALL_MASK5 : 8'hff;

    // Register 1: converter, rx1, tx1, sync port1, t1 gate, t2, t1 ovf
    pie_en_reg #(
        .WMASK   (`PIE_WMASK1)
    ) u_en1 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (we_en1),
        .wdata   (wd8),
        .lmask   (8'hff),
        .q       (en1)
    );
    // Register 2: osc fail, sync port2, collisions, voltage, t3
    pie_en_reg #(
        .WMASK   (`PIE_WMASK2)
    ) u_en2 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (we_en2),
        .wdata   (wd8),
        .lmask   (8'hff),
        .q       (en2)
    );
    // Register 3: rx2/tx2 enables are read-only zero
    pie_en_reg #(
        .WMASK   (`PIE_WMASK3)
    ) u_en3 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (we_en3),
        .wdata   (wd8),
        .lmask   (8'hff),
        .q       (en3)
    );
    // Register 4: capture/compare 10 down to 3
    pie_en_reg #(
        .WMASK   (`PIE_WMASK4)
    ) u_en4 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (we_en4),
        .wdata   (wd8),
        .lmask   (lm4),
        .q       (en4)
    );
    // Register 5: timer group
    pie_en_reg #(
        .WMASK   (`PIE_WMASK5)
    ) u_en5 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (we_en5),
        .wdata   (wd8),
        .lmask   (lm5),
        .q       (en5)
    );
    // Register 6: write done and comparators
    pie_en_reg #(
        .WMASK   (`PIE_WMASK6)
    ) u_en6 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (we_en6),
        .wdata   (wd8),
        .lmask   (8'hff),
        .q       (en6)
    );

    // ------------------------------------------------------------------------
    // Request gating
    // ------------------------------------------------------------------------
    wire [7:0] en3_eff = lcd_ok ? en3 : (en3 & ~(8'h01 << `PIE_LCD_BIT));
    wire [7:0] rq1;
    wire [7:0] rq2;
    wire [7:0] rq3;
    wire [7:0] rq4;
    wire [7:0] rq5;
    wire [7:0] rq6;
    wire [5:0] any_g;

    pie_gate u_g1 (
        .flags   (flags1),
        .enables (en1),
        .req     (rq1),
        .any     (any_g[0])
    );
    pie_gate u_g2 (
        .flags   (flags2),
        .enables (en2),
        .req     (rq2),
        .any     (any_g[1])
    );
    pie_gate u_g3 (
        .flags   (flags3),
        .enables (en3_eff),
        .req     (rq3),
        .any     (any_g[2])
    );
    pie_gate u_g4 (
        .flags   (flags4),
        .enables (en4),
        .req     (rq4),
        .any     (any_g[3])
    );
    pie_gate u_g5 (
        .flags   (flags5),
        .enables (en5),
        .req     (rq5),
        .any     (any_g[4])
    );
    pie_gate u_g6 (
        .flags   (flags6),
        .enables (en6),
        .req     (rq6),
        .any     (any_g[5])
    );

    // Enables only gate; flags are cleared at their source
    wire any_req = |any_g;
    wire req_d   = any_req & (prio_mode | glob_en);

    logic        req_q;
    logic [47:0] qreq_q;
    wire  [47:0] qreq_d = {rq6, rq5, rq4, rq3, rq2, rq1};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= 1'b0;
        end else begin
            req_q <= req_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qreq_q <= 48'h0;
        end else begin
            qreq_q <= qreq_d;
        end
    end
    assign periph_irq_req = req_q;
    assign qualified_req  = qreq_q;

    // ------------------------------------------------------------------------
    // Sticky status, mask and interrupt
    // ------------------------------------------------------------------------
    logic [`PIE_ST_W-1:0] stat_q;
    logic [`PIE_ST_W-1:0] stat_d;
    logic [`PIE_ST_W-1:0] imask_q;
    logic [`PIE_ST_W-1:0] imask_d;
    wire  [`PIE_ST_W-1:0] ev;
    assign ev[`PIE_ST_CHANGE] = req_d & ~req_q;
    assign ev[`PIE_ST_ERR]    = bad_acc;
    // Set wins over the read clear
    assign stat_d  = (rd_st ? {`PIE_ST_W{1'b0}} : stat_q) | ev;
    assign imask_d = we_msk ? pwdata[`PIE_ST_W-1:0] : imask_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= {`PIE_ST_W{1'b0}};
        end else begin
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_q <= {`PIE_ST_W{1'b0}};
        end else begin
            imask_q <= imask_d;
        end
    end
    assign irq = |(stat_q & imask_q);

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    wire [31:0] rd_mux =
          hit_en1 ? {24'h0, en1}
        : hit_en2 ? {24'h0, en2}
        : hit_en3 ? {24'h0, en3}
        : hit_en4 ? {24'h0, en4}
        : hit_en5 ? {24'h0, en5}
        : hit_en6 ? {24'h0, en6}
        : hit_ctl ? {27'h0, ctrl_q}
        : hit_st  ? {30'h0, stat_q}
        : hit_msk ? {30'h0, imask_q}
        : hit_rlo ? {qreq_q[31:0]}
        : hit_rhi ? {16'h0, qreq_q[47:32]}
        : 32'h0;
    assign prdata = rd_acc ? rd_mux : 32'h0;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_gate_block: assert property (@(posedge pclk) disable iff (!presetn)
        (flags1[0] && !en1[0]) |-> !rq1[0]) else $error("Disabled source passed");
    a_gate_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (flags1[0] && en1[0]) |=> qualified_req[0]) else $error("Enabled source blocked");
    a_bank_off: assert property (@(posedge pclk) disable iff (!presetn)
        (en2 == 8'h00) |=> (qualified_req[15:8] == 8'h00)) else $error("Request passed with bank off");
    a_reset_zero: assert property (@(posedge pclk)
        $rose(presetn) |-> (en1 == 8'h00 && en6 == 8'h00)) else $error("Enable not zero after reset");
    a_reset_rest: assert property (@(posedge pclk)
        $rose(presetn) |-> ({en2, en3, en4, en5} == 32'h0)) else $error("Enable not zero after reset");
    a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !en1[7] && !en2[6] && (en6 & 8'he8) == 8'h00) else $error("Unimplemented bit set");
    a_unimpl_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && hit_en6) |-> (prdata & 32'hffffffe8) == 32'h0) else $error("Unimplemented bit read as one");
    a_ro_bits: assert property (@(posedge pclk) disable iff (!presetn)
        en3[5:4] == 2'b00) else $error("Read-only enable bits set");
    a_lcd_mode: assert property (@(posedge pclk) disable iff (!presetn)
        !lcd_ok |-> !rq3[6]) else $error("Display request passed in wrong mode");
    a_lcd_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (lcd_ok && flags3[6] && en3[6]) |-> rq3[6]) else $error("Display request blocked in valid mode");
    a_small_var: assert property (@(posedge pclk) disable iff (!presetn)
        small_var |=> (en4[7:6] == 2'b00 && (en5 & 8'he8) == 8'h00)) else $error("Small variant bit set");
    a_reg6_map: assert property (@(posedge pclk) disable iff (!presetn)
        (flags6[4] && en6[4]) |=> qualified_req[44]) else $error("Write done request lost");
    a_global_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (!prio_mode && !glob_en) |=> !periph_irq_req) else $error("Request without global enable");
    a_glob_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (glob_en && |{rq6, rq5, rq4, rq3, rq2, rq1}) |=> periph_irq_req) else $error("Request not raised");
    a_or_req: assert property (@(posedge pclk) disable iff (!presetn)
        (prio_mode && |{rq6, rq5, rq4, rq3, rq2, rq1}) |=> periph_irq_req) else $error("Request not raised");
    a_req_drop: assert property (@(posedge pclk) disable iff (!presetn)
        !(|{rq6, rq5, rq4, rq3, rq2, rq1}) |=> !periph_irq_req) else $error("Request without source");
    a_write_en: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_en4 && !small_var) |=> en4 == $past(pwdata[7:0])) else $error("Enable write lost");
    a_err_status: assert property (@(posedge pclk) disable iff (!presetn)
        bad_acc |=> stat_q[`PIE_ST_ERR]) else $error("Bus error not recorded");
endmodule
`default_nettype wire

// >>> pie_defines.svh
// Register offsets, implemented-bit masks and reset values of the enable bank
// Assumes inclusion by bare name from the package and the design modules
`ifndef PIE_DEFINES_SVH
`define PIE_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define PIE_OFF_EN1      12'h000
`define PIE_OFF_EN2      12'h004
`define PIE_OFF_EN3      12'h008
`define PIE_OFF_EN4      12'h00c
`define PIE_OFF_EN5      12'h010
`define PIE_OFF_EN6      12'h014
`define PIE_OFF_CTRL     12'h018
`define PIE_OFF_STAT     12'h01c
`define PIE_OFF_IMASK    12'h020
`define PIE_OFF_REQ_LO   12'h024
`define PIE_OFF_REQ_HI   12'h028

// ----------------------------------------------------------------------------
// Sizes and masks
// ----------------------------------------------------------------------------
`define PIE_NREG         6
`define PIE_AW           12
`define PIE_RST8         8'h00
`define PIE_WMASK1       8'h7f
`define PIE_WMASK2       8'hbf
`define PIE_WMASK3       8'hcf
`define PIE_WMASK4       8'hff
`define PIE_WMASK5       8'hff
`define PIE_WMASK6       8'h17
`define PIE_SMALL_MASK4  8'h3f
`define PIE_SMALL_MASK5  8'h17
`define PIE_RMASK3       8'hff
`define PIE_LCD_BIT      6
`define PIE_CTRL_SMALL   0
`define PIE_CTRL_LCDB    1
`define PIE_CTRL_NSTAT   2
`define PIE_CTRL_GLOBAL  3
`define PIE_CTRL_PRIO    4
`define PIE_CTRL_W       5
`define PIE_CTRL_RST     5'h00
`define PIE_ST_CHANGE    0
`define PIE_ST_ERR       1
`define PIE_ST_W         2

`endif

// >>> pie_en_reg.sv
// One enable register: stores the writable bits, others read zero
// Assumes a write strobe from the bus decoder and a synchronous clock
`timescale 1ns/1ps
`default_nettype none
`include "pie_defines.svh"

module pie_en_reg #(
    parameter logic [7:0] WMASK = 8'hff
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Write side
    input  wire logic        wr,
    input  wire logic [7:0]  wdata,
    input  wire logic [7:0]  lmask,
    // Stored value
    output logic      [7:0]  q
);
    logic [7:0] en_q;
    logic [7:0] en_d;

    // Unimplemented and read-only positions never take a write
    assign en_d = wr ? (wdata & WMASK & lmask) : (en_q & lmask);
    assign q    = en_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= `PIE_RST8;
        end else begin
            en_q <= en_d;
        end
    end
endmodule
`default_nettype wire

// >>> pie_gate.sv
// Flag-and-enable gating for one eight-bit group of sources
// Assumes flags are held by the peripherals and stay until cleared there
`timescale 1ns/1ps
`default_nettype none

module pie_gate (
    // Flags and enables
    input  wire logic [7:0] flags,
    input  wire logic [7:0] enables,
    // Qualified requests
    output logic      [7:0] req,
    output logic            any
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            assign req[i] = flags[i] & enables[i];
        end
    endgenerate
    assign any = |req;
endmodule
`default_nettype wire

// >>> pie_pkg.sv
// Types shared by the enable bank modules
// Assumes pie_defines.svh is on the include path
`default_nettype none
`include "pie_defines.svh"

package pie_pkg;
    typedef logic [7:0] pie_byte_t;
    typedef enum logic [1:0] {
        PIE_IDLE   = 2'b00,
        PIE_ACCESS = 2'b01
    } pie_apb_st_t;
endpackage
`default_nettype wire

// >>> pie_src_model.sv
// Model of the peripheral flag sources facing the enable bank
// Assumes the bench pulses event and clear vectors right after pclk edges
`timescale 1ns/1ps
`default_nettype none

module pie_src_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Hardware events and software clears
    input  wire logic [47:0] set_ev,
    input  wire logic [47:0] clr_ev,
    // Flag levels
    output logic      [7:0]  flags1,
    output logic      [7:0]  flags2,
    output logic      [7:0]  flags3,
    output logic      [7:0]  flags4,
    output logic      [7:0]  flags5,
    output logic      [7:0]  flags6
);
    logic [47:0] flags_q;
    logic [47:0] flags_d;

    // Flags hold until software clears them; enables never touch them
    assign flags_d = (flags_q & ~clr_ev) | set_ev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end
    assign {flags6, flags5, flags4, flags3, flags2, flags1} = flags_q;
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the enable bank
// Assumes pie_defines.svh on the include path and the flag source model
`timescale 1ns/1ps
`default_nettype none
`include "pie_defines.svh"

module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        periph_irq_req, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  f1, f2, f3, f4, f5, f6;
    logic [47:0] qualified_req, set_ev, clr_ev;
    logic        err;
    int          miscompares, n_compared;
    logic [7:0]  msk [6] = '{8'h7f, 8'hbf, 8'hcf, 8'hff, 8'hff, 8'h17};

    pie_bank pie_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flags1(f1), .flags2(f2), .flags3(f3), .flags4(f4), .flags5(f5), .flags6(f6),
        .periph_irq_req(periph_irq_req), .qualified_req(qualified_req), .irq(irq));
    pie_src_model pie_src_model_inst (.pclk(pclk), .presetn(presetn), .set_ev(set_ev), .clr_ev(clr_ev),
        .flags1(f1), .flags2(f2), .flags3(f3), .flags4(f4), .flags5(f5), .flags6(f6));

    always #12.5 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) chk("pready", 1, 0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 4'h1);
    endtask

    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask

    task automatic complete_run();
        $display("Counts: %0d compared, %0d miscompares", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_access();
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, `PIE_OFF_EN1 + 12'(4 * i), '0, 4'h0);
            chk("reset value", 0, rd);
            wr(`PIE_OFF_EN1 + 12'(4 * i), 8'hff);
            apb(1'b0, `PIE_OFF_EN1 + 12'(4 * i), '0, 4'h0);
            chk("implemented bits", {40'h0, msk[i]}, rd);
            apb(1'b1, `PIE_OFF_EN1 + 12'(4 * i), 32'h0, 4'h0);
            apb(1'b0, `PIE_OFF_EN1 + 12'(4 * i), '0, 4'h0);
            chk("strobe off ignored", {40'h0, msk[i]}, rd);
            wr(`PIE_OFF_EN1 + 12'(4 * i), 8'h00);
            apb(1'b0, `PIE_OFF_EN1 + 12'(4 * i), '0, 4'h0);
            chk("cleared", 0, rd);
        end
        apb(1'b0, 12'h030, '0, 4'h0);
        chk("unmapped error", 1, err);
        wr(`PIE_OFF_REQ_LO, 8'hff);
        chk("read-only error", 1, err);
        $display("t_access done");
    endtask

    task automatic t_gate();
        wr(`PIE_OFF_CTRL, 8'h0e);
        @(posedge pclk) set_ev <= '1;
        @(posedge pclk) set_ev <= '0;
        for (int i = 0; i < 6; i++) begin
            wr(`PIE_OFF_EN1 + 12'(4 * i), 8'hff);
            settle();
            chk("qualified", 48'(msk[i]) << (8 * i), qualified_req);
            chk("core request", 1, periph_irq_req);
            apb(1'b0, (i < 4) ? `PIE_OFF_REQ_LO : `PIE_OFF_REQ_HI, '0, 4'h0);
            chk("request word", (48'(msk[i]) << (8 * i)) >> ((i < 4) ? 0 : 32), rd);
            if (i == 0) begin
                @(posedge pclk) clr_ev <= 48'h1;
                @(posedge pclk) clr_ev <= '0;
                settle();
                chk("flag low blocks", 48'h7e, qualified_req);
                @(posedge pclk) set_ev <= 48'h1;
                @(posedge pclk) set_ev <= '0;
            end
            wr(`PIE_OFF_EN1 + 12'(4 * i), 8'h00);
            settle();
            chk("disabled", 0, qualified_req);
            chk("core idle", 0, periph_irq_req);
        end
        $display("t_gate done");
    endtask

    task automatic t_modes();
        logic [7:0] c [3] = '{8'h08, 8'h0a, 8'h0e};
        wr(`PIE_OFF_EN3, 8'h40);
        for (int k = 0; k < 3; k++) begin
            wr(`PIE_OFF_CTRL, c[k]);
            settle();
            chk("display gate", (k == 2), qualified_req[22]);
        end
        wr(`PIE_OFF_EN3, 8'h00);
        wr(`PIE_OFF_EN1, 8'h01);
        for (int k = 0; k < 3; k++) begin
            wr(`PIE_OFF_CTRL, (k == 0) ? 8'h00 : ((k == 1) ? 8'h08 : 8'h10));
            settle();
            chk("global enable", (k != 0), periph_irq_req);
        end
        wr(`PIE_OFF_EN1, 8'h00);
        wr(`PIE_OFF_CTRL, 8'h0f);
        wr(`PIE_OFF_EN4, 8'hff);
        wr(`PIE_OFF_EN5, 8'hff);
        apb(1'b0, `PIE_OFF_EN4, '0, 4'h0);
        chk("small reg4", 32'h3f, rd);
        apb(1'b0, `PIE_OFF_EN5, '0, 4'h0);
        chk("small reg5", 32'h17, rd);
        apb(1'b0, `PIE_OFF_CTRL, '0, 4'h0);
        chk("control", 32'h0f, rd);
        wr(`PIE_OFF_EN4, 8'h00);
        wr(`PIE_OFF_EN5, 8'h00);
        wr(`PIE_OFF_CTRL, 8'h0e);
        $display("t_modes done");
    endtask

    task automatic t_irq();
        apb(1'b0, `PIE_OFF_STAT, '0, 4'h0);
        wr(`PIE_OFF_IMASK, 8'h01);
        apb(1'b0, `PIE_OFF_IMASK, '0, 4'h0);
        chk("mask", 32'h1, rd);
        settle();
        chk("irq idle", 0, irq);
        wr(`PIE_OFF_EN6, 8'h01);
        settle();
        chk("irq raised", 1, irq);
        apb(1'b0, `PIE_OFF_STAT, '0, 4'h0);
        chk("status", 32'h1, rd);
        settle();
        chk("irq cleared", 0, irq);
        wr(`PIE_OFF_IMASK, 8'h00);
        apb(1'b0, 12'h030, '0, 4'h0);
        settle();
        chk("irq masked", 0, irq);
        apb(1'b0, `PIE_OFF_STAT, '0, 4'h0);
        chk("error status", 32'h2, rd);
        wr(`PIE_OFF_EN6, 8'h00);
        $display("t_irq done");
    endtask

    task automatic t_reset();
        wr(`PIE_OFF_EN1, 8'h7f);
        wr(`PIE_OFF_EN6, 8'h17);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, `PIE_OFF_EN1 + 12'(4 * i), '0, 4'h0);
            chk("mid-run reset", 0, rd);
        end
        apb(1'b0, `PIE_OFF_CTRL, '0, 4'h0);
        chk("control reset", 0, rd);
        settle();
        chk("requests after reset", 0, qualified_req);
        chk("core after reset", 0, {periph_irq_req, irq});
        $display("t_reset done");
    endtask

    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; pstrb = '0; set_ev = '0; clr_ev = '0;
        miscompares = 0; n_compared = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_access();
        t_gate();
        t_modes();
        t_irq();
        t_reset();
        complete_run();
    end

    initial begin
        #(25 * 20000);
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire
